// ===== dv/ctrl_motor_model.sv
// Purpose: controller and motor model facing the forced-stop sequencer
// Assumes: one clock; the motor follows the speed command while the base is on
// Notes: behavioural only
`timescale 1ns/1ps
`default_nettype none
module ctrl_motor_model (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic link_up_in,
  input wire logic [47:0] cmd_set_in,
  input wire logic [47:0] speed_cmd_in,
  input wire logic [2:0] base_on_in,
  output logic link_ok_out = 1'b1,
  output logic [47:0] controller_cmd_out = 48'h0,
  output logic [47:0] speed_out = 48'h0
);
  ////////////////////////////////////////////////////////////////////////////////
  // Link state and command, refreshed every cycle like a cyclic network frame
  always @(posedge mclk_in) begin
    link_ok_out <= link_up_in;
    controller_cmd_out <= cmd_set_in;
  end
  // Motor: tracks the command under power, coasts down one step a cycle without
  always @(posedge mclk_in) begin
    for (int g = 0; g < 3; g++) begin
      if (reset_in) begin
        speed_out[16*g +: 16] <= 16'h0;
      end else if (base_on_in[g]) begin
        speed_out[16*g +: 16] <= speed_cmd_in[16*g +: 16];
      end else if (speed_out[16*g +: 16] != 16'h0) begin
        speed_out[16*g +: 16] <= speed_out[16*g +: 16] - 16'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== dv/forced_stop_sequencer_chk.sv
// Purpose: port checks for the forced-stop sequencer
// Assumes: one clock, synchronous active-high reset
// Notes: bound from the bench top file
`timescale 1ns/1ps
`default_nettype none
module forced_stop_sequencer_chk (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic forced_stop_input_n_in,
  input wire logic safe_torque_off_input_n_in,
  input wire logic all_axis_alarm_in,
  input wire logic all_axis_alarm_cause_in,
  input wire logic all_axis_alarm_db_in,
  input wire logic [2:0] axis_alarm_cause_in,
  input wire logic [2:0] axis_alarm_db_in,
  input wire logic [2:0] torque_mode_in,
  input wire logic [2:0] in_position_in,
  input wire logic [15:0] shutoff_delay_param_in,
  input wire logic shutoff_delay_enable_in,
  input wire logic [1:0] output_pin_assign_param_in,
  input wire logic [47:0] speed_cmd_out,
  input wire logic [2:0] base_on_out,
  input wire logic [2:0] dyn_brake_out,
  input wire logic [2:0] brake_interlock_output_out,
  input wire logic forced_stop_warning_out,
  input wire logic torque_off_timing_alarm_out,
  input wire logic [2:0] alarm_active_out,
  input wire logic all_axis_in_position_out
);
  default clocking dc @(posedge mclk_in); endclocking
  default disable iff (reset_in);
  ////////////////////////////////////////////////////////////////////////////////
  reset_state_a: assert property (disable iff (1'b0) reset_in |=> base_on_out == 3'h7
    && brake_interlock_output_out == 3'h7 && dyn_brake_out == 3'h0 && speed_cmd_out == 48'h0)
    else $error("state after reset wrong");
  warn_on_a: assert property ($fell(forced_stop_input_n_in) |-> ##[1:2] forced_stop_warning_out)
    else $error("warning missing after forced stop");
  brake_excl_a: assert property ((dyn_brake_out & base_on_out) == 3'h0)
    else $error("dynamic brake with base on");
  cut_order_a: assert property ($fell(base_on_out[0]) && !all_axis_alarm_db_in
    |-> !brake_interlock_output_out[0]) else $error("base cut before interlock drop");
  delay_hold_a: assert property ($fell(brake_interlock_output_out[0]) && shutoff_delay_enable_in
    && shutoff_delay_param_in > 16'h1 && safe_torque_off_input_n_in && !all_axis_alarm_db_in
    && !axis_alarm_db_in[0] |=> base_on_out[0] [*8]) else $error("shut-off delay too short");
  sto_err_a: assert property (forced_stop_warning_out && brake_interlock_output_out[0]
    && base_on_out[0] && !torque_mode_in[0] && $fell(safe_torque_off_input_n_in)
    |-> ##[0:3] torque_off_timing_alarm_out) else $error("torque-off timing alarm missing");
  alarm_hold_a: assert property (alarm_active_out[1]
    && (axis_alarm_cause_in[1] || all_axis_alarm_cause_in) |=> alarm_active_out[1])
    else $error("alarm cleared while cause present");
  db_alarm_a: assert property ($rose(all_axis_alarm_in) && all_axis_alarm_db_in
    |-> ##[1:3] dyn_brake_out == 3'h7) else $error("dynamic brake alarm not braking");
  pin_map_a: assert property (output_pin_assign_param_in == 2'h0 ##1
    output_pin_assign_param_in == 2'h0 |-> all_axis_in_position_out == &$past(in_position_in))
    else $error("pin not showing all-axis in-position");
  // Main scenarios reached
  cov_stop_c: cover property ($rose(forced_stop_warning_out));
  cov_cut_c: cover property ($fell(base_on_out[0]));
  cov_sto_c: cover property ($rose(torque_off_timing_alarm_out));
endmodule
`default_nettype wire

// ===== dv/tb_forced_stop_sequencer.sv
// Purpose: self-checking bench for the forced-stop sequencer
// Assumes: 10 MHz clock; ms counts run off the design's internal tick
// Notes: notes queue is drained by a monitor at every falling edge
`timescale 1ns/1ps
`default_nettype none
module tb_forced_stop_sequencer;
  logic mclk_in = 1'b0, reset_in = 1'b1, forced_stop_input_n_in = 1'b1, link_up = 1'b1;
  logic safe_torque_off_input_n_in = 1'b1, all_axis_alarm_in = 1'b0, cpu_reset_cmd_in = 1'b0;
  logic all_axis_alarm_cause_in = 1'b0, all_axis_alarm_db_in = 1'b0, error_reset_cmd_in = 1'b0;
  logic [2:0] axis_alarm_in = 3'h0, axis_alarm_cause_in = 3'h0, axis_alarm_db_in = 3'h0;
  logic [2:0] servo_on_cmd_in = 3'h7, torque_mode_in = 3'h0, in_position_in = 3'h0;
  logic [47:0] cmd_set = 48'h0, decel_time_constant_param_in = {3{16'h0064}};
  // Shut-off delay about 1.5 times the shortest no-fall delay
  logic [15:0] zero_speed_threshold_param_in = 16'h000a, shutoff_delay_param_in = 16'h0002;
  logic [15:0] freefall_comp_amount_param_in = 16'h0, electronic_brake_duration_param_in = 16'h1;
  logic shutoff_delay_enable_in = 1'b0, electronic_brake_enable_param_in = 1'b0;
  logic [3:0] stop_function_select_param_in = 4'h2;
  logic [1:0] output_pin_assign_param_in = 2'h0;
  wire link_ok_in, forced_stop_warning_out, torque_off_timing_alarm_out, all_axis_in_position_out;
  wire [47:0] speed_in, controller_cmd_in, speed_cmd_out;
  wire [2:0] base_on_out, dyn_brake_out, electronic_brake_out, brake_interlock_output_out;
  wire [2:0] pullup_out, alarm_active_out;
  logic [31:0] rng = 32'hcebcb180;
  int miscompares = 0, cmp_count = 0;
  typedef struct {int sel; logic [47:0] exp;} note_t;
  note_t notes[$];
  string nm[11] = '{"base_on", "brake_interlock", "dyn_brake", "pullup", "warning",
    "torque_off_alarm", "alarm_active", "in_position_pin", "speed_cmd", "speed_cmd0_low",
    "electronic_brake"};
  ////////////////////////////////////////////////////////////////////////////////
  ctrl_motor_model model_u (.mclk_in(mclk_in), .reset_in(reset_in), .link_up_in(link_up),
    .cmd_set_in(cmd_set), .speed_cmd_in(speed_cmd_out), .base_on_in(base_on_out),
    .link_ok_out(link_ok_in), .controller_cmd_out(controller_cmd_in), .speed_out(speed_in));
  forced_stop_sequencer dut_u (.*);
  // Clock, 100 ns period
  initial begin
    forever #50 mclk_in = ~mclk_in;
  end
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [47:0] seen(int sel);
    case (sel)
      0: return {45'h0, base_on_out};
      1: return {45'h0, brake_interlock_output_out};
      2: return {45'h0, dyn_brake_out};
      3: return {45'h0, pullup_out};
      4: return {47'h0, forced_stop_warning_out};
      5: return {47'h0, torque_off_timing_alarm_out};
      6: return {45'h0, alarm_active_out};
      7: return {47'h0, all_axis_in_position_out};
      8: return speed_cmd_out;
      9: return {47'h0, speed_cmd_out[15:0] < 16'd1000};
      default: return {45'h0, electronic_brake_out};
    endcase
  endfunction
  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction
  // Inputs always move 2 ns after the rising edge
  task automatic step(int n);
    repeat (n) @(posedge mclk_in);
    #2;
  endtask
  task automatic note(int sel, logic [47:0] exp);
    notes.push_back('{sel, exp});
  endtask
  // Bounded wait for a level, then leave the note for the monitor
  task automatic expect_in(int sel, logic [47:0] exp, int lim);
    int k = 0;
    while (seen(sel) !== exp && k < lim) begin
      step(1);
      k++;
    end
    note(sel, exp);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    step(1);
    s = 1'b0;
  endtask
  task automatic restart();
    servo_on_cmd_in = 3'h0;
    step(2);
    servo_on_cmd_in = 3'h7;
    expect_in(0, 48'h7, 20);
  endtask
  task automatic check(string what, logic [47:0] got, logic [47:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Monitor: falling edge is clear of every output update
  initial begin : monitor
    note_t n;
    forever begin
      @(negedge mclk_in);
      while (notes.size() > 0) begin
        n = notes.pop_front();
        check(nm[n.sel], seen(n.sel), n.exp);
      end
    end
  end
  // Watchdog, well beyond the longest expected run
  initial begin
    #10_000_000;
    miscompares++;
    end_sim();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin : main
    logic [31:0] r;
    step(3);
    reset_in = 1'b0;
    note(1, 48'h7);
    note(8, 48'h0);
    for (int i = 0; i < 8; i++) begin
      r = xs();
      cmd_set = {6'h0, r[9:0], 6'h0, r[19:10], 6'h0, r[29:20]};
      in_position_in = r[2:0];
      output_pin_assign_param_in = r[31:30];
      step(3);
      note(8, cmd_set);
      note(7, {47'h0, (r[31:30] == 2'h0) ? &r[2:0] : (r[31:30] == 2'h1)});
    end
    output_pin_assign_param_in = 2'h0;
    cmd_set = 48'h0;
    step(5);
    $display("test run_path done");
    // Stop at zero speed: pull-up, interlock, then cut after the delay
    freefall_comp_amount_param_in = 16'h0010;
    shutoff_delay_enable_in = 1'b1;
    forced_stop_input_n_in = 1'b0;
    expect_in(4, 48'h1, 3);
    expect_in(3, 48'h7, 5);
    expect_in(1, 48'h0, 5);
    step(4000);
    note(0, 48'h7);
    expect_in(0, 48'h0, 25000);
    note(2, 48'h7);
    forced_stop_input_n_in = 1'b1;
    step(20);
    note(0, 48'h0);
    note(4, 48'h1);
    restart();
    expect_in(4, 48'h0, 3);
    $display("test zero_speed_stop done");
    // Decel from speed, torque-off drop, then a braking alarm cuts in
    cmd_set = {3{16'd1000}};
    electronic_brake_enable_param_in = 1'b1;
    step(6);
    forced_stop_input_n_in = 1'b0;
    step(30);
    note(1, 48'h7);
    step(11000);
    note(9, 48'h1);
    safe_torque_off_input_n_in = 1'b0;
    expect_in(5, 48'h1, 4);
    all_axis_alarm_db_in = 1'b1;
    all_axis_alarm_cause_in = 1'b1;
    pulse(all_axis_alarm_in);
    expect_in(2, 48'h7, 4);
    note(10, 48'h7);
    note(6, 48'h7);
    safe_torque_off_input_n_in = 1'b1;
    pulse(error_reset_cmd_in);
    step(3);
    note(6, 48'h7);
    all_axis_alarm_cause_in = 1'b0;
    all_axis_alarm_db_in = 1'b0;
    pulse(cpu_reset_cmd_in);
    step(3);
    note(6, 48'h0);
    note(5, 48'h0);
    forced_stop_input_n_in = 1'b1;
    restart();
    $display("test decel_abort done");
    // Per-axis alarm with deceleration switched off
    stop_function_select_param_in = 4'h0;
    step(6);
    axis_alarm_cause_in = 3'h2;
    axis_alarm_in = 3'h2;
    step(1);
    axis_alarm_in = 3'h0;
    expect_in(1, 48'h5, 5);
    note(6, 48'h2);
    expect_in(0, 48'h5, 25000);
    axis_alarm_cause_in = 3'h0;
    pulse(error_reset_cmd_in);
    step(3);
    note(6, 48'h0);
    stop_function_select_param_in = 4'h2;
    restart();
    $display("test axis_alarm done");
    // Link loss decelerates speed-mode axes; the torque-mode axis brakes
    step(6);
    link_up = 1'b0;
    torque_mode_in = 3'h4;
    step(11000);
    note(9, 48'h1);
    note(1, 48'h3);
    note(0, 48'h3);
    $display("test link_loss done");
    step(2);
    end_sim();
  end
endmodule
bind forced_stop_sequencer forced_stop_sequencer_chk chk_u (.*);
`default_nettype wire

// ===== src/axis_stop_ctrl.v
// Purpose: one axis of the forced-stop sequence
// Assumes: speed magnitude in r/min, ms tick from parent
// Notes: see main file for the behaviour list
`timescale 1ns/1ps
`default_nettype none
`include "stop_seq_consts.vh"

module axis_stop_ctrl (
  input wire mclk_in,
  input wire reset_in,
  input wire tick_ms_in,
  input wire stop_req_in,
  input wire db_alarm_in,
  input wire torque_mode_in,
  input wire decel_en_in,
  input wire delay_en_in,
  input wire release_in,
  input wire safe_torque_off_input_in,
  input wire [`SPEED_W-1:0] speed_in,
  input wire [`SPEED_W-1:0] controller_cmd_in,
  input wire [`PARAM_W-1:0] decel_time_constant_param_in,
  input wire [`SPEED_W-1:0] zero_speed_threshold_param_in,
  input wire [`PARAM_W-1:0] shutoff_delay_param_in,
  input wire [`PARAM_W-1:0] freefall_comp_amount_param_in,
  input wire electronic_brake_enable_param_in,
  input wire [`PARAM_W-1:0] electronic_brake_duration_param_in,
  output reg [`SPEED_W-1:0] speed_cmd_out,
  output reg base_on_out,
  output reg dyn_brake_out,
  output reg electronic_brake_out,
  output reg brake_interlock_output_out,
  output reg pullup_out,
  output reg sto_timing_err_out,
  output wire stopping_out
);

  reg [2:0] state;
  reg [`PARAM_W-1:0] ms_cnt;
  reg [`PARAM_W-1:0] step_cnt;
  reg [`SPEED_W-1:0] step;
  wire at_zero;
  wire below_zero;
  wire [`SPEED_W-1:0] ramp_div;

  assign at_zero = (speed_in <= zero_speed_threshold_param_in);
  assign below_zero = (speed_in < zero_speed_threshold_param_in);
  // Only used when the time constant is nonzero
  assign ramp_div = speed_in / decel_time_constant_param_in;
  assign stopping_out = (state != `ST_RUN);

  ////////////////////////////////////////////////////////////////////////
  // Sequencer
  always @(posedge mclk_in) begin
    if (reset_in) begin
      state <= `ST_RUN;
      ms_cnt <= 16'h0000;
      step_cnt <= 16'h0000;
      step <= 16'h0000;
      speed_cmd_out <= 16'h0000;
      base_on_out <= 1'b1;
      dyn_brake_out <= 1'b0;
      electronic_brake_out <= 1'b0;
      brake_interlock_output_out <= 1'b1;
      pullup_out <= 1'b0;
      sto_timing_err_out <= 1'b0;
    end else begin
      // Timing error is a level while the fault stands in deceleration
      sto_timing_err_out <= 1'b0;
      case (state)
        `ST_RUN: begin
          speed_cmd_out <= controller_cmd_in;
          base_on_out <= 1'b1;
          dyn_brake_out <= 1'b0;
          brake_interlock_output_out <= 1'b1;
          pullup_out <= 1'b0;
          ms_cnt <= 16'h0000;
          if (stop_req_in) begin
            if (db_alarm_in || torque_mode_in || !decel_en_in) begin
              state <= `ST_DYN_BRAKE;
            end else if (at_zero) begin
              brake_interlock_output_out <= 1'b0;
              // Pull-up only with nonzero amount and delay enabled
              if (delay_en_in && freefall_comp_amount_param_in != 16'h0000) begin
                pullup_out <= 1'b1;
                state <= `ST_PULLUP;
              end else begin
                state <= `ST_BRAKE_WAIT;
              end
            end else begin
              // Ramp step per ms so speed reaches zero in decel time
              step <= (decel_time_constant_param_in == 16'h0000) ? speed_in :
                      (ramp_div == 16'h0000) ? 16'h0001 : ramp_div;
              speed_cmd_out <= speed_in;
              state <= `ST_DECEL;
            end
          end
        end
        `ST_DECEL: begin
          if (!safe_torque_off_input_in) begin
            sto_timing_err_out <= 1'b1;
          end
          if (db_alarm_in) begin
            state <= `ST_DYN_BRAKE;
          end else if (below_zero) begin
            brake_interlock_output_out <= 1'b0;
            state <= `ST_BRAKE_WAIT;
          end else if (tick_ms_in) begin
            // Internal model command, not the controller's
            speed_cmd_out <= (speed_cmd_out > step) ?
                             speed_cmd_out - step : 16'h0000;
          end
        end
        `ST_BRAKE_WAIT, `ST_PULLUP: begin
          speed_cmd_out <= 16'h0000;
          if (db_alarm_in) begin
            state <= `ST_DYN_BRAKE;
          end else if (!delay_en_in || ms_cnt >= shutoff_delay_param_in) begin
            pullup_out <= 1'b0;
            state <= `ST_DYN_BRAKE;
          end else if (tick_ms_in) begin
            ms_cnt <= ms_cnt + 16'h0001;
          end
        end
        `ST_DYN_BRAKE: begin
          // Base cut and dynamic brake, at whatever speed this state is entered
          base_on_out <= 1'b0;
          dyn_brake_out <= 1'b1;
          brake_interlock_output_out <= 1'b0;
          pullup_out <= 1'b0;
          speed_cmd_out <= 16'h0000;
          step_cnt <= 16'h0000;
          electronic_brake_out <= electronic_brake_enable_param_in &&
                                  (speed_in >= `EBRAKE_MIN_RPM);
          state <= `ST_STOPPED;
        end
        `ST_STOPPED: begin
          // Electronic brake held for its duration once started, unless a restart clears it first
          if (electronic_brake_out) begin
            if (step_cnt >= electronic_brake_duration_param_in) begin
              electronic_brake_out <= 1'b0;
            end else if (tick_ms_in) begin
              step_cnt <= step_cnt + 16'h0001;
            end
          end
          // Restart needs stop cleared, alarms cleared, and servo-on
          if (release_in && !stop_req_in) begin
            sto_timing_err_out <= 1'b0;
            electronic_brake_out <= 1'b0;
            state <= `ST_RUN;
          end
        end
        default: begin
          state <= `ST_RUN;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// ===== src/forced_stop_sequencer.v
// Purpose: forced-stop, alarm and link-loss stop sequencing for three axes
// Assumes: synchronous inputs; parameters are static during a sequence
// Notes: speeds are magnitudes in r/min; times in ms
`timescale 1ns/1ps
`default_nettype none
`include "stop_seq_consts.vh"

module forced_stop_sequencer (
  input wire mclk_in,
  input wire reset_in,
  input wire forced_stop_input_n_in,
  input wire link_ok_in,
  input wire safe_torque_off_input_n_in,
  input wire all_axis_alarm_in,
  input wire all_axis_alarm_cause_in,
  input wire all_axis_alarm_db_in,
  input wire [`NUM_AXES-1:0] axis_alarm_in,
  input wire [`NUM_AXES-1:0] axis_alarm_cause_in,
  input wire [`NUM_AXES-1:0] axis_alarm_db_in,
  input wire error_reset_cmd_in,
  input wire cpu_reset_cmd_in,
  input wire [`NUM_AXES-1:0] servo_on_cmd_in,
  input wire [`NUM_AXES-1:0] torque_mode_in,
  input wire [`NUM_AXES-1:0] in_position_in,
  input wire [`NUM_AXES*`SPEED_W-1:0] speed_in,
  input wire [`NUM_AXES*`SPEED_W-1:0] controller_cmd_in,
  input wire [`NUM_AXES*`PARAM_W-1:0] decel_time_constant_param_in,
  input wire [`SPEED_W-1:0] zero_speed_threshold_param_in,
  input wire [`PARAM_W-1:0] shutoff_delay_param_in,
  input wire shutoff_delay_enable_in,
  input wire [`PARAM_W-1:0] freefall_comp_amount_param_in,
  input wire [3:0] stop_function_select_param_in,
  input wire electronic_brake_enable_param_in,
  input wire [`PARAM_W-1:0] electronic_brake_duration_param_in,
  input wire [1:0] output_pin_assign_param_in,
  output wire [`NUM_AXES*`SPEED_W-1:0] speed_cmd_out,
  output wire [`NUM_AXES-1:0] base_on_out,
  output wire [`NUM_AXES-1:0] dyn_brake_out,
  output wire [`NUM_AXES-1:0] electronic_brake_out,
  output wire [`NUM_AXES-1:0] brake_interlock_output_out,
  output wire [`NUM_AXES-1:0] pullup_out,
  output reg forced_stop_warning_out,
  output reg torque_off_timing_alarm_out,
  output reg [`NUM_AXES-1:0] alarm_active_out,
  output reg all_axis_in_position_out
);

  reg [`TICK_W-1:0] tick_cnt;
  reg tick_ms;
  reg all_alarm;
  reg [`NUM_AXES-1:0] axis_alarm;
  reg [3:0] stop_fn;
  wire [`NUM_AXES-1:0] stopping;
  wire [`NUM_AXES-1:0] sto_err;
  wire [`NUM_AXES-1:0] stop_req;
  wire [`NUM_AXES-1:0] db_alarm;
  wire [`NUM_AXES-1:0] restart_ok;
  reg [`NUM_AXES-1:0] servo_on_q;
  wire clear_cmd;
  wire decel_en;
  wire em_stop;

  assign clear_cmd = error_reset_cmd_in | cpu_reset_cmd_in;
  assign em_stop = !forced_stop_input_n_in;
  assign decel_en = (stop_fn == `STOP_FN_ENABLED);

  ////////////////////////////////////////////////////////////////////////
  // Millisecond tick for all timed steps
  always @(posedge mclk_in) begin
    if (reset_in) begin
      tick_cnt <= 14'h0000;
      tick_ms <= 1'b0;
    end else if (tick_cnt == `TICK_MS_CYCLES - 1) begin
      tick_cnt <= 14'h0000;
      tick_ms <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 14'h0001;
      tick_ms <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Stop-function setting latched; reset value is the enabled code
  always @(posedge mclk_in) begin
    if (reset_in) begin
      stop_fn <= `STOP_FN_RESET;
    end else begin
      stop_fn <= stop_function_select_param_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sticky alarms; a new event beats a clear in the same cycle, and
  // a clear is refused while the cause is still present.
  always @(posedge mclk_in) begin
    if (reset_in) begin
      all_alarm <= 1'b0;
      axis_alarm <= 3'h0;
      torque_off_timing_alarm_out <= 1'b0;
    end else begin
      if (all_axis_alarm_in) begin
        all_alarm <= 1'b1;
      end else if (clear_cmd && !all_axis_alarm_cause_in) begin
        all_alarm <= 1'b0;
      end
      axis_alarm <= axis_alarm_in | (axis_alarm &
                    ~(clear_cmd ? ~axis_alarm_cause_in : 3'h0));
      if (|sto_err) begin
        torque_off_timing_alarm_out <= 1'b1;
      end else if (clear_cmd && !safe_torque_off_input_n_in) begin
        torque_off_timing_alarm_out <= torque_off_timing_alarm_out;
      end else if (clear_cmd) begin
        torque_off_timing_alarm_out <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Stop requests per axis: shared input and link loss hit every axis,
  // all-axis alarm hits every axis, per-axis alarm only its own.
  assign stop_req = {`NUM_AXES{em_stop | !link_ok_in | all_alarm}} | axis_alarm;
  assign db_alarm = ({`NUM_AXES{all_alarm & all_axis_alarm_db_in}} |
                    (axis_alarm & axis_alarm_db_in));
  assign restart_ok = servo_on_cmd_in & ~servo_on_q & ~axis_alarm &
                      {`NUM_AXES{!all_alarm}};

  ////////////////////////////////////////////////////////////////////////
  // Servo-on history; restart needs a fresh servo-on, not a held level.
  // Reset value matches the held-on level so no false edge follows reset.
  always @(posedge mclk_in) begin
    if (reset_in) begin
      servo_on_q <= 3'h7;
    end else begin
      servo_on_q <= servo_on_cmd_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Axis sequencers
  genvar g;
  generate
    for (g = 0; g < `NUM_AXES; g = g + 1) begin : axis
      axis_stop_ctrl u_axis (
        .mclk_in(mclk_in),
        .reset_in(reset_in),
        .tick_ms_in(tick_ms),
        .stop_req_in(stop_req[g]),
        .db_alarm_in(db_alarm[g]),
        .torque_mode_in(torque_mode_in[g]),
        .decel_en_in(decel_en),
        .delay_en_in(shutoff_delay_enable_in),
        .release_in(restart_ok[g]),
        .safe_torque_off_input_in(safe_torque_off_input_n_in),
        .speed_in(speed_in[g*`SPEED_W +: `SPEED_W]),
        .controller_cmd_in(controller_cmd_in[g*`SPEED_W +: `SPEED_W]),
        .decel_time_constant_param_in(decel_time_constant_param_in[g*`PARAM_W +: `PARAM_W]),
        .zero_speed_threshold_param_in(zero_speed_threshold_param_in),
        .shutoff_delay_param_in(shutoff_delay_param_in),
        .freefall_comp_amount_param_in(freefall_comp_amount_param_in),
        .electronic_brake_enable_param_in(electronic_brake_enable_param_in),
        .electronic_brake_duration_param_in(electronic_brake_duration_param_in),
        .speed_cmd_out(speed_cmd_out[g*`SPEED_W +: `SPEED_W]),
        .base_on_out(base_on_out[g]),
        .dyn_brake_out(dyn_brake_out[g]),
        .electronic_brake_out(electronic_brake_out[g]),
        .brake_interlock_output_out(brake_interlock_output_out[g]),
        .pullup_out(pullup_out[g]),
        .sto_timing_err_out(sto_err[g]),
        .stopping_out(stopping[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Status outputs; warning held while forced-stop sequence runs
  always @(posedge mclk_in) begin
    if (reset_in) begin
      forced_stop_warning_out <= 1'b0;
      alarm_active_out <= 3'h0;
      all_axis_in_position_out <= 1'b0;
    end else begin
      // Held after release until every axis is back in run
      forced_stop_warning_out <= em_stop | (forced_stop_warning_out & (|stopping));
      alarm_active_out <= axis_alarm | {`NUM_AXES{all_alarm}};
      case (output_pin_assign_param_in)
        `PIN_SEL_IN_POSITION: all_axis_in_position_out <= &in_position_in;
        `PIN_SEL_BRAKE: all_axis_in_position_out <= &brake_interlock_output_out;
        `PIN_SEL_ALARM: all_axis_in_position_out <= all_alarm | (|axis_alarm);
        `PIN_SEL_WARNING: all_axis_in_position_out <= em_stop;
        default: all_axis_in_position_out <= &in_position_in;
      endcase
    end
  end

endmodule
`default_nettype wire

// ===== src/stop_seq_consts.vh
// Purpose: constants for the forced-stop sequencer
// Assumes: 10 MHz clock, parameters given in ms or r/min units
// Notes: definitions only
`ifndef STOP_SEQ_CONSTS_VH
`define STOP_SEQ_CONSTS_VH

`define NUM_AXES 3
`define SPEED_W 16
`define PARAM_W 16
// Clock rate and one-millisecond tick
`define CLK_HZ 10000000
`define TICK_MS_CYCLES (`CLK_HZ / 1000)
`define TICK_W 14
// Stop function selection leading digit values
`define STOP_FN_ENABLED 4'h2
`define STOP_FN_DISABLED 4'h0
`define STOP_FN_RESET 4'h2
// Electronic brake speed floor in r/min
`define EBRAKE_MIN_RPM 16'h0005
// Output pin source select codes
`define PIN_SEL_IN_POSITION 2'h0
`define PIN_SEL_BRAKE 2'h1
`define PIN_SEL_ALARM 2'h2
`define PIN_SEL_WARNING 2'h3
// Axis sequencer states
`define ST_RUN 3'h0
`define ST_DECEL 3'h1
`define ST_BRAKE_WAIT 3'h2
`define ST_PULLUP 3'h3
`define ST_DYN_BRAKE 3'h4
`define ST_STOPPED 3'h5

`endif
